/* logic/fecs_defines.svh */
// Purpose: Constants of the flash erase command sequencer, both ends
// Assumes: 16-bit data bus, word addressing, 20 MHz clock
// Notes:   Window count follows the clock rate below
`ifndef FECS_DEFINES_SVH
`define FECS_DEFINES_SVH

`define FECS_UNLOCK_A1     11'h555
`define FECS_UNLOCK_A2     11'h2aa
`define FECS_D_UNLOCK1     16'h00aa
`define FECS_D_UNLOCK2     16'h0055
`define FECS_D_SETUP       16'h0080
`define FECS_D_SECTOR      16'h0030
`define FECS_D_CHIP        16'h0010
`define FECS_D_WB_LOAD     16'h0025
`define FECS_D_WB_CONFIRM  16'h0029
`define FECS_D_RESET       16'h00f0
`define FECS_D_SUSPEND     16'h00b0
`define FECS_D_ERASED      16'hffff
`define FECS_D_ZERO        16'h0000
`define FECS_BUF_WORDS     32
`define FECS_PAGE_BITS     5

`define FECS_BIT_POLL      7
`define FECS_BIT_TOGGLE    6
`define FECS_BIT_TLIMIT    5
`define FECS_BIT_WINDOW    3
`define FECS_BIT_STOGGLE   2
`define FECS_BIT_ABORT     1

`define FECS_CLK_MHZ       20
`define FECS_WINDOW_US     50
`define FECS_WINDOW_CYC    (`FECS_WINDOW_US * `FECS_CLK_MHZ)

`endif

/* logic/fecs_pkg.sv */
// Purpose: Types shared by both ends of the flash erase command sequencer
// Assumes: Nothing beyond the defines header
// Notes:   Device states are one-hot
package fecs_pkg;
	typedef enum logic [14:0] {
		S_READ   = 15'h0001,
		S_UNL1   = 15'h0002,
		S_UNL2   = 15'h0004,
		S_SETUP  = 15'h0008,
		S_UNL4   = 15'h0010,
		S_UNL5   = 15'h0020,
		S_WINDOW = 15'h0040,
		S_ERASE  = 15'h0080,
		S_WB_CNT = 15'h0100,
		S_WB_LD  = 15'h0200,
		S_WB_CNF = 15'h0400,
		S_PROG   = 15'h0800,
		S_ABORT  = 15'h1000,
		S_ABT1   = 15'h2000,
		S_ABT2   = 15'h4000
	} fecs_state_t;

	typedef enum logic [2:0] {
		OP_SECTOR_ERASE = 3'h0,
		OP_CHIP_ERASE   = 3'h1,
		OP_ADD_SECTOR   = 3'h2,
		OP_WB_PROGRAM   = 3'h3,
		OP_ABORT_RESET  = 3'h4,
		OP_READ_RESET   = 3'h5
	} fecs_op_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'h1,
		H_RUN  = 2'h2
	} fecs_host_state_t;
endpackage : fecs_pkg

/* logic/fecs_if.sv */
// Purpose: Flash command bus between host and device
// Assumes: One clock; wr_en is the one-cycle write strobe
// Notes:   Read data answers one cycle after rd_en
interface fecs_if #(
	parameter int ADDR_W = 13
);
	logic              wr_en;
	logic              rd_en;
	logic [ADDR_W-1:0] addr;
	logic [15:0]       wdata;
	logic [15:0]       rdata;
	logic              rvalid;

	modport dev  (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
	modport host (output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface : fecs_if

/* logic/fecs_device.sv */
// Purpose: Flash command decoder, erase and buffered program engine with array
// Assumes: Address is bank | sector | word, unlock offsets in the low 11 bits
// Notes:   Suspend is not supported; a suspend write in the window is ignored
`include "fecs_defines.svh"

module fecs_device #(
	parameter int ADDR_W     = 13,
	parameter int BANK_W     = 2,
	parameter int SECT_W     = 4,
	parameter int WINDOW_CYC = `FECS_WINDOW_CYC
)(
	input  wire logic                 clk,
	input  wire logic                 resetn,
	fecs_if.dev                       bus,
	output fecs_pkg::fecs_state_t     dev_state,
	output logic [(1<<SECT_W)-1:0]    erase_set
);
	import fecs_pkg::*;

	localparam int NSECT = 1 << SECT_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int PG_W  = ADDR_W - `FECS_PAGE_BITS;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] d,
		input logic [10:0] ua, input logic [15:0] code);
		return (a[10:0] == ua) && (d == code);
	endfunction : hit

	function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1 -: SECT_W];
	endfunction : sect_of

	function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1 -: BANK_W];
	endfunction : bank_of

	logic [15:0]        mem [DEPTH];
	fecs_state_t        state_q, state_d;
	logic [BANK_W-1:0]  op_bank_q;
	logic [NSECT-1:0]   sect_set_q;
	logic               chip_q;
	logic [15:0]        win_cnt_q;
	logic [SECT_W-1:0]  wb_sect_q;
	logic [PG_W-1:0]    wb_page_q;
	logic [5:0]         wb_left_q;
	logic               wb_first_q;
	logic [15:0]        buf_q [`FECS_BUF_WORDS];
	logic [31:0]        buf_vld_q;
	logic [15:0]        last_data_q;
	logic [ADDR_W-1:0]  ptr_q;
	logic               pass_q;
	logic               toggle_q;
	logic               stoggle_q;
	logic [15:0]        rdata_q;
	logic               rvalid_q;
	logic               add_sect, clr_set, chip_go, wb_go, cnt_go, ld_go, prog_go;
	logic               eng_done, stat_bank;
	logic [15:0]        status;

	wire                wr = bus.wr_en;
	wire [ADDR_W-1:0]   a  = bus.addr;
	wire [15:0]         d  = bus.wdata;

	assign dev_state  = state_q;
	assign erase_set  = sect_set_q;
	assign bus.rdata  = rdata_q;
	assign bus.rvalid = rvalid_q;

	assign eng_done = (state_q == S_ERASE) ? (pass_q && (&ptr_q)) : (&ptr_q[`FECS_PAGE_BITS-1:0]);

	// ****************************************************************
	// Command sequence
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		add_sect = 1'b0;
		clr_set = 1'b0;
		chip_go = 1'b0;
		wb_go = 1'b0;
		cnt_go = 1'b0;
		ld_go = 1'b0;
		prog_go = 1'b0;
		unique case (state_q)
			S_READ: if (wr && hit(a, d, `FECS_UNLOCK_A1, `FECS_D_UNLOCK1)) state_d = S_UNL1;
			S_UNL1: if (wr) state_d = hit(a, d, `FECS_UNLOCK_A2, `FECS_D_UNLOCK2) ? S_UNL2 : S_READ;
			S_UNL2: if (wr) begin
				if (hit(a, d, `FECS_UNLOCK_A1, `FECS_D_SETUP)) begin
					state_d = S_SETUP;
				end else if (d == `FECS_D_WB_LOAD) begin
					state_d = S_WB_CNT;
					wb_go = 1'b1;
				end else begin
					state_d = S_READ;
				end
			end
			S_SETUP: if (wr) state_d = hit(a, d, `FECS_UNLOCK_A1, `FECS_D_UNLOCK1) ? S_UNL4 : S_READ;
			S_UNL4: if (wr) state_d = hit(a, d, `FECS_UNLOCK_A2, `FECS_D_UNLOCK2) ? S_UNL5 : S_READ;
			S_UNL5: if (wr) begin
				if (d == `FECS_D_SECTOR) begin
					state_d = S_WINDOW;
					add_sect = 1'b1;
				end else if (hit(a, d, `FECS_UNLOCK_A1, `FECS_D_CHIP)) begin
					state_d = S_ERASE;
					chip_go = 1'b1;
				end else begin
					state_d = S_READ;
				end
			end
			S_WINDOW: if (wr) begin
				if (d == `FECS_D_SECTOR) begin
					add_sect = 1'b1;
				end else if (d != `FECS_D_SUSPEND) begin
					state_d = S_READ;
					clr_set = 1'b1;
				end
			end else if (win_cnt_q == 16'h0000) begin
				state_d = S_ERASE;
			end
			S_WB_CNT: if (wr) begin
				if (sect_of(a) == wb_sect_q && d[15:5] == 11'h000) begin
					state_d = S_WB_LD;
					cnt_go = 1'b1;
				end else begin
					state_d = S_ABORT;
				end
			end
			S_WB_LD: if (wr) begin
				if (sect_of(a) == wb_sect_q && (wb_first_q || a[ADDR_W-1:`FECS_PAGE_BITS] == wb_page_q)) begin
					ld_go = 1'b1;
					if (wb_left_q == 6'h01) state_d = S_WB_CNF;
				end else begin
					state_d = S_ABORT;
				end
			end
			S_WB_CNF: if (wr) begin
				if (sect_of(a) == wb_sect_q && d == `FECS_D_WB_CONFIRM) begin
					state_d = S_PROG;
					prog_go = 1'b1;
				end else begin
					state_d = S_ABORT;
				end
			end
			// Writes are not decoded here at all while the engine runs
			S_ERASE: if (eng_done) state_d = S_READ;
			S_PROG: if (eng_done) state_d = S_READ;
			S_ABORT: if (wr && hit(a, d, `FECS_UNLOCK_A1, `FECS_D_UNLOCK1)) state_d = S_ABT1;
			S_ABT1: if (wr) state_d = hit(a, d, `FECS_UNLOCK_A2, `FECS_D_UNLOCK2) ? S_ABT2 : S_ABORT;
			S_ABT2: if (wr) state_d = hit(a, d, `FECS_UNLOCK_A1, `FECS_D_RESET) ? S_READ : S_ABORT;
			default: state_d = S_READ;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= S_READ;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************************************
	// Erase target set and accept window
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sect_set_q <= '0;
			chip_q <= 1'b0;
			op_bank_q <= '0;
		end else begin
			if (state_q == S_READ && state_d == S_UNL1) op_bank_q <= bank_of(a);
			if (add_sect) sect_set_q[sect_of(a)] <= 1'b1;
			if (chip_go) chip_q <= 1'b1;
			if (clr_set || (state_q == S_ERASE && eng_done)) begin
				sect_set_q <= '0;
				chip_q <= 1'b0;
			end
		end
	end

	// Restarting on every select keeps the window at least its length after the last select
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			win_cnt_q <= 16'h0000;
		end else if (add_sect) begin
			win_cnt_q <= 16'(WINDOW_CYC - 1);
		end else if (state_q == S_WINDOW && win_cnt_q != 16'h0000) begin
			win_cnt_q <= win_cnt_q - 16'h0001;
		end
	end

	// ****************************************************************
	// Write buffer loading
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wb_sect_q <= '0;
			wb_page_q <= '0;
			wb_left_q <= 6'h00;
			wb_first_q <= 1'b0;
			buf_vld_q <= 32'h0000_0000;
			last_data_q <= 16'h0000;
		end else begin
			if (wb_go) begin
				wb_sect_q <= sect_of(a);
				buf_vld_q <= 32'h0000_0000;
			end
			if (cnt_go) begin
				wb_left_q <= {1'b0, d[4:0]} + 6'h01;
				wb_first_q <= 1'b1;
			end
			if (ld_go) begin
				if (wb_first_q) wb_page_q <= a[ADDR_W-1:`FECS_PAGE_BITS];
				wb_first_q <= 1'b0;
				wb_left_q <= wb_left_q - 6'h01;
				buf_vld_q[a[`FECS_PAGE_BITS-1:0]] <= 1'b1;
				last_data_q <= d;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (ld_go) buf_q[a[`FECS_PAGE_BITS-1:0]] <= d;
	end

	// ****************************************************************
	// Embedded engine: preprogram pass then erase pass, or buffer program
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ptr_q <= '0;
			pass_q <= 1'b0;
		end else if (state_q != S_ERASE && state_q != S_PROG) begin
			ptr_q <= '0;
			pass_q <= 1'b0;
		end else begin
			ptr_q <= ptr_q + 1'b1;
			if (&ptr_q) pass_q <= 1'b1;
		end
	end

	// The array is never reset so a hardware reset leaves partial erases visible
	always_ff @(posedge clk) begin
		if (state_q == S_ERASE && (chip_q || sect_set_q[sect_of(ptr_q)])) begin
			mem[ptr_q] <= pass_q ? `FECS_D_ERASED : `FECS_D_ZERO;
		end
		if (state_q == S_PROG && buf_vld_q[ptr_q[`FECS_PAGE_BITS-1:0]]) begin
			mem[{wb_page_q, ptr_q[`FECS_PAGE_BITS-1:0]}] <=
				mem[{wb_page_q, ptr_q[`FECS_PAGE_BITS-1:0]}] & buf_q[ptr_q[`FECS_PAGE_BITS-1:0]];
		end
	end

	// ****************************************************************
	// Read path and status
	// ****************************************************************
	assign stat_bank = (state_q inside {S_WINDOW, S_ERASE, S_PROG, S_ABORT, S_ABT1, S_ABT2}) &&
		(bank_of(a) == op_bank_q);

	always_comb begin
		status = 16'h0000;
		status[`FECS_BIT_POLL] = (state_q == S_WINDOW || state_q == S_ERASE) ? 1'b0 : ~last_data_q[7];
		status[`FECS_BIT_TOGGLE] = toggle_q;
		status[`FECS_BIT_TLIMIT] = 1'b0;
		status[`FECS_BIT_WINDOW] = (state_q == S_ERASE);
		status[`FECS_BIT_STOGGLE] = stoggle_q;
		status[`FECS_BIT_ABORT] = (state_q inside {S_ABORT, S_ABT1, S_ABT2});
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
			toggle_q <= 1'b0;
			stoggle_q <= 1'b0;
		end else begin
			rvalid_q <= bus.rd_en;
			if (bus.rd_en) begin
				if (stat_bank) begin
					rdata_q <= status;
					toggle_q <= ~toggle_q;
					if (chip_q || sect_set_q[sect_of(a)]) stoggle_q <= ~stoggle_q;
				end else begin
					rdata_q <= mem[a];
				end
			end
		end
	end
endmodule : fecs_device

/* logic/fecs_host.sv */
// Purpose: Host end that turns user commands into flash write sequences
// Assumes: User keeps sector selects inside the accept window and buffer loads inside one page
// Notes:   One write per cycle, reads only while idle
`include "fecs_defines.svh"

module fecs_host #(
	parameter int ADDR_W = 13,
	parameter int BANK_W = 2
)(
	input  wire logic               clk,
	input  wire logic               resetn,
	fecs_if.host                    bus,
	input  wire logic               cmd_valid,
	output logic                    cmd_ready,
	input  fecs_pkg::fecs_op_t      cmd_op,
	input  wire logic [ADDR_W-1:0]  cmd_addr,
	input  wire logic [4:0]         cmd_count,
	input  wire logic [15:0]        ld_data,
	output logic                    ld_take,
	input  wire logic               rd_req,
	input  wire logic [ADDR_W-1:0]  rd_addr,
	output logic [15:0]             rd_data,
	output logic                    rd_valid
);
	import fecs_pkg::*;

	fecs_host_state_t   st_q;
	fecs_op_t           op_q;
	logic [ADDR_W-1:0]  ta_q;
	logic [4:0]         cnt_q;
	logic [5:0]         step_q;
	logic [5:0]         last;
	logic [ADDR_W-1:0]  nxt_a;
	logic [15:0]        nxt_d;
	logic               wr_q, rd_q;
	logic [ADDR_W-1:0]  addr_q;
	logic [15:0]        wdata_q;

	assign cmd_ready = (st_q == H_IDLE);
	assign bus.wr_en = wr_q;
	assign bus.rd_en = rd_q;
	assign bus.addr  = addr_q;
	assign bus.wdata = wdata_q;

	// ****************************************************************
	// Sequence tables
	// ****************************************************************
	function automatic logic [5:0] steps_of(input fecs_op_t op, input logic [4:0] n);
		unique case (op)
			OP_SECTOR_ERASE, OP_CHIP_ERASE: return 6'd5;
			OP_WB_PROGRAM:                  return 6'({1'b0, n} + 6'd5);
			OP_ABORT_RESET:                 return 6'd2;
			default:                        return 6'd0;
		endcase
	endfunction : steps_of

	wire [ADDR_W-1:0] base = {ta_q[ADDR_W-1 -: BANK_W], {(ADDR_W-BANK_W){1'b0}}};
	wire [ADDR_W-1:0] ua1  = base | ADDR_W'(`FECS_UNLOCK_A1);
	wire [ADDR_W-1:0] ua2  = base | ADDR_W'(`FECS_UNLOCK_A2);

	assign last = steps_of(op_q, cnt_q);

	always_comb begin
		nxt_a = ta_q;
		nxt_d = `FECS_D_SECTOR;
		ld_take = 1'b0;
		unique case (op_q)
			OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
				unique case (step_q)
					6'd0, 6'd3: begin nxt_a = ua1; nxt_d = `FECS_D_UNLOCK1; end
					6'd1, 6'd4: begin nxt_a = ua2; nxt_d = `FECS_D_UNLOCK2; end
					6'd2:       begin nxt_a = ua1; nxt_d = `FECS_D_SETUP; end
					default: begin
						if (op_q == OP_CHIP_ERASE) begin
							nxt_a = ua1;
							nxt_d = `FECS_D_CHIP;
						end
					end
				endcase
			end
			OP_WB_PROGRAM: begin
				if (step_q == 6'd0) begin nxt_a = ua1; nxt_d = `FECS_D_UNLOCK1; end
				else if (step_q == 6'd1) begin nxt_a = ua2; nxt_d = `FECS_D_UNLOCK2; end
				else if (step_q == 6'd2) nxt_d = `FECS_D_WB_LOAD;
				else if (step_q == 6'd3) nxt_d = {11'h000, cnt_q};
				else if (step_q == last) nxt_d = `FECS_D_WB_CONFIRM;
				else begin
					// Loads run on from the first address; a page crossing is left to the device to abort
					nxt_a = ta_q + ADDR_W'(step_q - 6'd4);
					nxt_d = ld_data;
					ld_take = (st_q == H_RUN);
				end
			end
			OP_ABORT_RESET: begin
				nxt_a = (step_q == 6'd1) ? ua2 : ua1;
				nxt_d = (step_q == 6'd0) ? `FECS_D_UNLOCK1 :
					(step_q == 6'd1) ? `FECS_D_UNLOCK2 : `FECS_D_RESET;
			end
			OP_READ_RESET: nxt_d = `FECS_D_RESET;
			default: nxt_d = `FECS_D_SECTOR;
		endcase
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= H_IDLE;
			op_q <= OP_READ_RESET;
			ta_q <= '0;
			cnt_q <= 5'h00;
			step_q <= 6'd0;
		end else if (st_q == H_IDLE) begin
			if (cmd_valid) begin
				st_q <= H_RUN;
				op_q <= cmd_op;
				ta_q <= cmd_addr;
				cnt_q <= cmd_count;
				step_q <= 6'd0;
			end
		end else begin
			step_q <= step_q + 6'd1;
			if (step_q == last) st_q <= H_IDLE;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= 16'h0000;
		end else begin
			wr_q <= (st_q == H_RUN);
			rd_q <= (st_q == H_IDLE) && rd_req && !cmd_valid;
			if (st_q == H_RUN) begin
				addr_q <= nxt_a;
				wdata_q <= nxt_d;
			end else if (rd_req) begin
				addr_q <= rd_addr;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= bus.rvalid;
			if (bus.rvalid) rd_data <= bus.rdata;
		end
	end
endmodule : fecs_host

/* test/fecs_monitor.sv */
// Purpose: Bus checker for the flash command link between host and device
// Assumes: Host sends each command as back-to-back writes, one per cycle
// Notes:   Sees only the shared bus, so device state is inferred from traffic
module fecs_monitor #(
	parameter int ADDR_W = 13
)(
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic              wr_en,
	input wire logic              rd_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [15:0]       wdata,
	input wire logic [15:0]       rdata,
	input wire logic              rvalid
);
	timeunit 1ns;
	timeprecision 1ns;

	logic        prev55_q;
	logic [1:0]  cbank_q;
	logic [15:0] cage_q;
	logic        w_aa, w_55, w_80, w_10, w_25, w_29, w_f0, st_rd;

	assign w_aa = wr_en && wdata == 16'h00aa && addr[10:0] == 11'h555;
	assign w_55 = wr_en && wdata == 16'h0055 && addr[10:0] == 11'h2aa;
	assign w_80 = wr_en && wdata == 16'h0080 && addr[10:0] == 11'h555;
	assign w_10 = wr_en && wdata == 16'h0010 && addr[10:0] == 11'h555;
	assign w_25 = wr_en && wdata == 16'h0025;
	assign w_29 = wr_en && wdata == 16'h0029;
	assign w_f0 = wr_en && wdata == 16'h00f0 && addr[10:0] == 11'h555;
	// Chip erase runs two 8192-cycle passes; only trust reads well inside that
	assign st_rd = rd_en && addr[ADDR_W-1 -: 2] == cbank_q && cage_q != 16'h0 && cage_q < 16'h3e80;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev55_q <= 1'b0;
		end else if (wr_en) begin
			prev55_q <= w_55;
		end
	end

	// Saturates so it never wraps back into the trusted range
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cage_q  <= 16'h0;
			cbank_q <= 2'h0;
		end else if (w_10 && prev55_q) begin
			cage_q  <= 16'h1;
			cbank_q <= addr[ADDR_W-1 -: 2];
		end else if (cage_q != 16'h0 && cage_q != 16'hffff) begin
			cage_q <= cage_q + 16'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_unl;
		w_aa ##1 w_55;
	endsequence

	property p_rd_answer;
		rvalid == $past(rd_en);
	endproperty
	property p_erase_seq;
		s_unl ##1 w_80 |=> s_unl ##1 (w_10 || (wr_en && wdata == 16'h0030));
	endproperty
	property p_chip_six;
		w_10 && prev55_q |-> $past(w_80, 3);
	endproperty
	property p_buf_span;
		s_unl ##1 w_25 |-> ##[3:34] w_29;
	endproperty
	property p_buf_order;
		s_unl ##1 w_25 |=> wr_en [*3];
	endproperty
	property p_chip_status;
		st_rd |=> rvalid && !rdata[7] && !rdata[5] && !rdata[1];
	endproperty
	property p_chip_window;
		st_rd |=> rdata[3];
	endproperty
	property p_recover;
		w_f0 && prev55_q |-> $past(w_aa, 2);
	endproperty

	a_rd_answer: assert property (p_rd_answer) else $error("read answer out of step");
	a_erase_seq: assert property (p_erase_seq) else $error("erase sequence broken");
	a_chip_six: assert property (p_chip_six) else $error("chip erase without setup");
	a_buf_span: assert property (p_buf_span) else $error("buffer confirm out of span");
	a_buf_order: assert property (p_buf_order) else $error("buffer writes not contiguous");
	a_chip_status: assert property (p_chip_status) else $error("bad erase status");
	a_chip_window: assert property (p_chip_window) else $error("window bit low in erase");
	a_recover: assert property (p_recover) else $error("recovery without unlock");
endmodule : fecs_monitor

/* test/flash_erase_command_sequencer_tb_top.sv */
// Purpose: Self-checking bench joining host and device ends over the flash bus
// Assumes: Accept window shortened to WIN cycles; array unknown until erased
// Notes:   Load words carry bit 15 so they never look like command codes
module flash_erase_command_sequencer_tb_top import fecs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int WIN = 12;

	logic        clk;
	logic        resetn;
	logic        cmd_valid;
	logic        cmd_ready;
	fecs_op_t    cmd_op;
	logic [12:0] cmd_addr;
	logic [4:0]  cmd_count;
	logic [15:0] ld_data;
	logic        ld_take;
	logic        rd_req;
	logic [12:0] rd_addr;
	logic [15:0] rd_data;
	logic        rd_valid;
	fecs_state_t dev_state;
	logic [15:0] erase_set;
	logic [15:0] lw [32];
	logic [31:0] rng;
	int          ld_idx;
	int          num_errors;
	int          tests_run;

	fecs_if bus_if ();

	fecs_device #(.WINDOW_CYC(WIN)) fecs_device_inst (
		.clk(clk), .resetn(resetn), .bus(bus_if), .dev_state(dev_state), .erase_set(erase_set));

	fecs_host fecs_host_inst (
		.clk(clk), .resetn(resetn), .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_count(cmd_count), .ld_data(ld_data),
		.ld_take(ld_take), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

	fecs_monitor fecs_monitor_inst (
		.clk(clk), .resetn(resetn), .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) if (ld_take === 1'b1) ld_idx <= ld_idx + 1;
	always @(negedge clk) ld_data <= lw[ld_idx];

	function automatic logic [31:0] nxt();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : nxt

	function automatic logic [15:0] exp_prog(input logic [15:0] old, input logic [15:0] d);
		return old & d;
	endfunction : exp_prog

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic bail();
		num_errors++;
		$display("CHECK FAILED t=%0t wait limit %h %h", $time, 16'h0, 16'h1);
		complete_run();
	endtask : bail

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic issue(input fecs_op_t op, input logic [12:0] a, input logic [4:0] n);
		int i;
		@(negedge clk);
		cmd_op    = op;
		cmd_addr  = a;
		cmd_count = n;
		ld_idx    = 0;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 60 && cmd_ready !== 1'b1; i++) @(negedge clk);
		if (i == 60) bail();
	endtask : issue

	task automatic rd(input logic [12:0] a, output logic [15:0] d);
		int i;
		@(negedge clk);
		rd_req  = 1'b1;
		rd_addr = a;
		@(negedge clk);
		rd_req = 1'b0;
		for (i = 0; i < 8 && rd_valid !== 1'b1; i++) @(negedge clk);
		if (i == 8) bail();
		d = rd_data;
	endtask : rd

	task automatic rc(input logic [12:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e);
	endtask : rc

	task automatic wait_read();
		int i;
		for (i = 0; i < 40000 && dev_state !== S_READ; i++) @(negedge clk);
		if (i == 40000) bail();
	endtask : wait_read

	initial begin
		logic [15:0] d1;
		logic [15:0] d2;
		logic [15:0] e0;
		logic [12:0] b0;
		logic [12:0] pb;
		int          n;
		resetn     = 1'b0;
		cmd_valid  = 1'b0;
		cmd_op     = OP_READ_RESET;
		cmd_addr   = 13'h0;
		cmd_count  = 5'h0;
		ld_data    = 16'h0;
		rd_req     = 1'b0;
		rd_addr    = 13'h0;
		ld_idx     = 0;
		rng        = 32'hf9695c35;
		num_errors = 0;
		tests_run  = 0;
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		issue(OP_CHIP_ERASE, 13'h0000, 5'h0);
		repeat (200) @(negedge clk);
		resetn = 1'b0;
		@(negedge clk);
		resetn = 1'b1;
		chk(16'(dev_state), 16'(S_READ));
		$display("test reset_abort done");
		issue(OP_CHIP_ERASE, 13'h0000, 5'h0);
		rd(13'h0123, d1);
		chk(d1 & 16'h00aa, 16'h0008);
		issue(OP_READ_RESET, 13'h0000, 5'h0);
		rd(13'h0123, d2);
		chk(d2 & 16'h00aa, 16'h0008);
		chk({15'h0, d1[6] ^ d2[6]}, 16'h1);
		wait_read();
		for (int i = 0; i < 8; i++) rc(13'(nxt()), 16'hffff);
		$display("test chip_erase done");
		// Full page first, then a random short count
		for (int k = 0; k < 2; k++) begin
			n = (k == 0) ? 31 : int'(nxt() % 31);
			pb = {2'b01, ~1'(k), 5'(nxt()), 5'h0};
			for (int i = 0; i < 32; i++) lw[i] = 16'(nxt()) | 16'h8000;
			b0 = (k == 0) ? pb : b0;
			e0 = (k == 0) ? lw[0] : e0;
			issue(OP_WB_PROGRAM, pb, 5'(n));
			rc(13'h1000, 16'hffff);
			wait_read();
			for (int i = 0; i <= n; i++) rc(pb + 13'(i), exp_prog(16'hffff, lw[i]));
			if (n < 31) rc(pb + 13'(n + 1), 16'hffff);
		end
		$display("test buffer_program done");
		for (int i = 0; i < 32; i++) lw[i] = 16'(nxt()) | 16'h8080;
		issue(OP_WB_PROGRAM, 13'h1a1e, 5'h3);
		rd(13'h1a1e, d1);
		rd(13'h1a1e, d2);
		chk(d1 & 16'h00a2, 16'h0002);
		chk({15'h0, d1[6] ^ d2[6]}, 16'h1);
		issue(OP_ABORT_RESET, 13'h1800, 5'h0);
		rc(13'h1a1e, 16'hffff);
		$display("test buffer_abort done");
		issue(OP_SECTOR_ERASE, b0, 5'h0);
		issue(OP_READ_RESET, b0, 5'h0);
		rc(b0, e0);
		issue(OP_SECTOR_ERASE, b0, 5'h0);
		issue(OP_ADD_SECTOR, 13'h0800, 5'h0);
		rd(b0, d1);
		chk(d1 & 16'h0088, 16'h0000);
		chk(erase_set, (16'h0001 << b0[12:9]) | 16'h0010);
		repeat (WIN + 8) @(negedge clk);
		issue(OP_READ_RESET, b0, 5'h0);
		rd(b0, d1);
		chk(d1 & 16'h0088, 16'h0008);
		wait_read();
		chk(erase_set, 16'h0000);
		rc(b0, 16'hffff);
		rc(13'h0800, 16'hffff);
		$display("test sector_erase done");
		complete_run();
	end
endmodule : flash_erase_command_sequencer_tb_top
